// *** inc/spi_clock_and_frame_config_regs.vh ***
/*
 * Register map, field positions, reset values and divider constants for
 * the serial port clock and frame configuration block.
 * Assumes a 12-bit APB byte address with one 32-bit word per register.
 */
`ifndef SPI_CLOCK_AND_FRAME_CONFIG_REGS_VH
`define SPI_CLOCK_AND_FRAME_CONFIG_REGS_VH

// ----------------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------------
`define CTL_ONE_OFS          12'h000
`define CTL_TWO_OFS          12'h004

// ----------------------------------------------------------------------
// Reset values and implemented-bit masks
// ----------------------------------------------------------------------
`define CTL_ONE_RESET        16'h0000
`define CTL_TWO_RESET        16'h0000
`define CTL_ONE_MASK         16'h1fff
`define CTL_TWO_MASK         16'he002

// ----------------------------------------------------------------------
// Control one field positions
// ----------------------------------------------------------------------
`define CLOCK_PIN_DISABLE    12
`define DATA_OUT_PIN_DISABLE 11
`define WORD_WIDTH_SELECT    10
`define SAMPLE_PHASE_SELECT  9
`define CLOCK_EDGE_SELECT    8
`define SLAVE_SELECT_ENABLE  7
`define CLOCK_POLARITY_SEL   6
`define MASTER_ROLE_SELECT   5
`define SEC_PRESCALER_HI     4
`define SEC_PRESCALER_LO     2
`define PRI_PRESCALER_HI     1
`define PRI_PRESCALER_LO     0

// ----------------------------------------------------------------------
// Control two field positions
// ----------------------------------------------------------------------
`define FRAMING_ENABLE       15
`define FRAME_SYNC_DIRECTION 14
`define FRAME_SYNC_POLARITY  13
`define FRAME_SYNC_EDGE_SEL  1

// ----------------------------------------------------------------------
// Divider ratios and word lengths in clock edges
// ----------------------------------------------------------------------
`define PRI_DIV_1            7'h01
`define PRI_DIV_4            7'h04
`define PRI_DIV_16           7'h10
`define PRI_DIV_64           7'h40
`define SEC_DIV_BASE         4'h8
`define EDGES_WORD           6'h20
`define EDGES_BYTE           6'h10

`endif

// *** src/spi_clock_and_frame_config.v ***
/*
 * Serial port clock and frame configuration with its bit engine: two
 * APB control registers steer role, word width, sampling, clock shape,
 * prescaler, pin release and framed operation of a small serial engine.
 * Assumes pins come from outside the pclk domain and a same-clock user
 * supplies transmit words; the APB master follows the usual handshake.
 */
`timescale 1ns/1ns
`include "spi_clock_and_frame_config_regs.vh"

module spi_clock_and_frame_config (
    input  wire        pclk,
    input  wire        presetn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    input  wire        serial_clock_pin_in,
    output reg         serial_clock_pin_out,
    output reg         serial_clock_pin_oe,
    input  wire        serial_in_pin,
    output reg         serial_out_pin_out,
    output reg         serial_out_pin_oe,
    input  wire        select_pin_in,
    output reg         select_pin_out,
    output reg         select_pin_oe,
    input  wire [15:0] tx_word,
    input  wire        tx_start,
    output reg         tx_busy,
    output reg  [15:0] rx_word,
    output reg         rx_valid
);

// ----------------------------------------------------------------------
// States
// ----------------------------------------------------------------------
localparam ST_IDLE = 3'b001;   // Waiting for a word
localparam ST_LEAD = 3'b010;   // Sync bit ahead of first bit
localparam ST_XFER = 3'b100;   // Shifting bits

reg  [15:0] ctl_one_q;         // Control register one
reg  [15:0] ctl_two_q;         // Control register two
reg  [2:0]  sync1_q;           // First synchroniser stage
reg  [2:0]  sync2_q;           // Second synchroniser stage
reg         sck_prev_q;        // Last synced clock level
reg  [10:0] div_q;             // Half-period divider
reg  [2:0]  state_q;           // Engine state
reg  [5:0]  edge_q;            // Edge index in word
reg  [15:0] tx_sr_q;           // Transmit shift register
reg  [15:0] rx_sr_q;           // Receive shift register
reg  [15:0] tx_hold_q;         // Word waiting to go
reg         pending_q;         // Master word requested
reg         armed_q;           // Received sync seen
reg         role_q;            // Role in the last cycle

// ----------------------------------------------------------------------
// Field decode
// ----------------------------------------------------------------------
wire        clk_dis   = ctl_one_q[`CLOCK_PIN_DISABLE];
wire        do_dis    = ctl_one_q[`DATA_OUT_PIN_DISABLE];
wire        w16       = ctl_one_q[`WORD_WIDTH_SELECT];
wire        sample_phase_select       = ctl_one_q[`SAMPLE_PHASE_SELECT];
wire        slave_select_enable      = ctl_one_q[`SLAVE_SELECT_ENABLE];
wire        cpol      = ctl_one_q[`CLOCK_POLARITY_SEL];
wire        master    = ctl_one_q[`MASTER_ROLE_SELECT];
wire [2:0]  sec_pre   = ctl_one_q[`SEC_PRESCALER_HI:`SEC_PRESCALER_LO];
wire [1:0]  pri_pre   = ctl_one_q[`PRI_PRESCALER_HI:`PRI_PRESCALER_LO];
wire        framed    = ctl_two_q[`FRAMING_ENABLE];
wire        fs_in     = ctl_two_q[`FRAME_SYNC_DIRECTION];
wire        fs_pol    = ctl_two_q[`FRAME_SYNC_POLARITY];
wire        fs_dly    = ctl_two_q[`FRAME_SYNC_EDGE_SEL];
wire        cke       = ctl_one_q[`CLOCK_EDGE_SELECT] & ~framed;

// ----------------------------------------------------------------------
// APB slave
// ----------------------------------------------------------------------
wire        setup     = psel & ~penable;
wire        hit_one   = (paddr == `CTL_ONE_OFS);
wire        hit_two   = (paddr == `CTL_TWO_OFS);
wire        wr_en     = psel & penable & pready & pwrite & ~pslverr;

// Answer one cycle into the access phase
always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        pready  <= 1'b0;
        pslverr <= 1'b0;
        prdata  <= 32'h0000_0000;
    end
    else
    begin
        pready  <= setup;
        pslverr <= setup & ~(hit_one | hit_two);
        if (setup)
        begin
            if (hit_one)
                prdata <= {16'h0000, ctl_one_q};
            else if (hit_two)
                prdata <= {16'h0000, ctl_two_q};
            else
                prdata <= 32'h0000_0000;
        end
    end
end

// Control registers, masked to implemented bits
always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        ctl_one_q <= `CTL_ONE_RESET;
        ctl_two_q <= `CTL_TWO_RESET;
    end
    else if (wr_en)
    begin
        if (hit_one)
            ctl_one_q <= pwdata[15:0] & `CTL_ONE_MASK;
        if (hit_two)
            ctl_two_q <= pwdata[15:0] & `CTL_TWO_MASK;
    end
end

// ----------------------------------------------------------------------
// Pin synchronisers: clock, select, data in
// ----------------------------------------------------------------------
always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        sync1_q    <= 3'h0;
        sync2_q    <= 3'h0;
        sck_prev_q <= 1'b0;
    end
    else
    begin
        sync1_q    <= {serial_in_pin, select_pin_in, serial_clock_pin_in};
        sync2_q    <= sync1_q;
        sck_prev_q <= sync2_q[0];
    end
end

wire        sck_s     = sync2_q[0];
wire        sel_s     = sync2_q[1];
wire        sdi_s     = sync2_q[2];
wire        fs_act    = (sel_s == fs_pol);
wire        sel_low   = ~sel_s;

// ----------------------------------------------------------------------
// Master bit clock divider
// ----------------------------------------------------------------------
reg  [6:0]  pri_f;             // Primary ratio
wire [3:0]  sec_f     = `SEC_DIV_BASE - {1'b0, sec_pre};
wire [10:0] half_w    = pri_f * sec_f;
wire        run       = master & ~clk_dis & ((state_q != ST_IDLE) | framed);
wire        tick      = run & (div_q == (half_w - 11'h001));

// Primary ratio decode
always @*
begin
    case (pri_pre)
        2'b11:   pri_f = `PRI_DIV_1;
        2'b10:   pri_f = `PRI_DIV_4;
        2'b01:   pri_f = `PRI_DIV_16;
        default: pri_f = `PRI_DIV_64;
    endcase
end

// Divider counts pclk cycles per half period
always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
        div_q <= 11'h000;
    else if (!run || tick)
        div_q <= 11'h000;
    else
        div_q <= div_q + 11'h001;
end

// ----------------------------------------------------------------------
// Engine decode
// ----------------------------------------------------------------------
wire [5:0]  edges_w   = w16 ? `EDGES_WORD : `EDGES_BYTE;
wire        pin_edge  = (sck_s != sck_prev_q);
wire        ev        = master ? tick : pin_edge;
wire        idle      = (state_q == ST_IDLE);
wire        sl_go     = framed ? (fs_dly ? fs_act : (armed_q & ~fs_act))
                               : (~slave_select_enable | sel_low);
wire        ms_go     = pending_q & (~(framed & fs_in) | fs_act)
                        & (serial_clock_pin_out == cpol) & ~tick & ~clk_dis;
wire        enter     = idle & (master ? ms_go : sl_go);
wire        to_lead   = master & framed & ~fs_in & ~fs_dly;
wire        act       = (state_q == ST_XFER) | (enter & ~to_lead);
wire [5:0]  e_cur     = (state_q == ST_XFER) ? edge_q : 6'h00;
wire        even      = ~e_cur[0];
wire        sol       = cke ^ sample_phase_select;
wire        samp_now  = sol ? (even & (cke ? (e_cur < edges_w) : (e_cur != 6'h00)))
                            : ~even;
wire        shift_now = cke ? ~even : (even & (e_cur != 6'h00) & (e_cur < edges_w));
wire        last      = master ? (e_cur == edges_w) : (e_cur == (edges_w - 6'h01));
wire        role_chg  = master ^ role_q;
wire        abort     = (~master & ~framed & slave_select_enable & ~sel_low) | role_chg;
wire [15:0] rx_next   = samp_now ? {rx_sr_q[14:0], sdi_s} : rx_sr_q;

// ----------------------------------------------------------------------
// Engine sequencing and shifting
// ----------------------------------------------------------------------
always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        state_q   <= ST_IDLE;
        edge_q    <= 6'h00;
        tx_sr_q   <= 16'h0000;
        rx_sr_q   <= 16'h0000;
        tx_hold_q <= 16'h0000;
        pending_q <= 1'b0;
        armed_q   <= 1'b0;
        role_q    <= 1'b0;
        rx_word   <= 16'h0000;
        rx_valid  <= 1'b0;
    end
    else
    begin
        rx_valid <= 1'b0;
        // Role seen last cycle, a change aborts the word
        role_q   <= master;
        // New word taken only while not busy
        if (tx_start && idle && !pending_q)
        begin
            tx_hold_q <= tx_word;
            pending_q <= master;
        end
        else if (enter)
            pending_q <= 1'b0;
        // Received sync arms a slave frame
        if (enter)
            armed_q <= 1'b0;
        else if (idle && framed && !master && fs_act)
            armed_q <= 1'b1;
        if (enter)
        begin
            tx_sr_q <= tx_hold_q;
            rx_sr_q <= 16'h0000;
            edge_q  <= 6'h00;
        end
        case (state_q)
            ST_IDLE:
            begin
                if (enter)
                    state_q <= to_lead ? ST_LEAD : ST_XFER;
            end
            ST_LEAD:
            begin
                // Two edges of sync, then data
                if (ev)
                begin
                    edge_q <= edge_q + 6'h01;
                    if (edge_q == 6'h01)
                    begin
                        edge_q  <= 6'h00;
                        state_q <= ST_XFER;
                    end
                end
            end
            ST_XFER:
            begin
                if (abort)
                begin
                    state_q <= ST_IDLE;
                    edge_q  <= 6'h00;
                end
            end
            default:
                state_q <= ST_IDLE;
        endcase
        if (act && ev && !abort)
        begin
            rx_sr_q <= rx_next;
            if (shift_now)
                tx_sr_q <= {tx_sr_q[14:0], 1'b0};
            edge_q <= e_cur + 6'h01;
            state_q <= ST_XFER;
            if (last)
            begin
                rx_word  <= w16 ? rx_next : {8'h00, rx_next[7:0]};
                rx_valid <= 1'b1;
                state_q  <= ST_IDLE;
                edge_q   <= 6'h00;
            end
        end
    end
end

// ----------------------------------------------------------------------
// Pin drivers, all registered
// ----------------------------------------------------------------------
wire        toggle    = tick & ((idle & framed) | (state_q == ST_LEAD)
                        | ((state_q == ST_XFER) & (edge_q < edges_w)));
wire        pulse     = master & framed & ~fs_in & ((state_q == ST_LEAD)
                        | (fs_dly & (state_q == ST_XFER) & (edge_q < 6'h02)));

always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        serial_clock_pin_out <= 1'b0;
        serial_clock_pin_oe  <= 1'b0;
        serial_out_pin_out   <= 1'b0;
        serial_out_pin_oe    <= 1'b0;
        select_pin_out       <= 1'b1;
        select_pin_oe        <= 1'b0;
        tx_busy              <= 1'b0;
    end
    else
    begin
        if (!run)
            serial_clock_pin_out <= cpol;
        else if (toggle)
            serial_clock_pin_out <= ~serial_clock_pin_out;
        serial_clock_pin_oe <= master & ~clk_dis;
        serial_out_pin_out  <= w16 ? tx_sr_q[15] : tx_sr_q[7];
        serial_out_pin_oe   <= ~do_dis & (master | framed | ~slave_select_enable | sel_low);
        select_pin_out      <= fs_pol ? pulse : ~pulse;
        select_pin_oe       <= framed & ~fs_in;
        tx_busy             <= pending_q | ~idle | (tx_start & idle & master);
    end
end

endmodule // spi_clock_and_frame_config

// *** tb/spi_cfg_checker.sv ***
/*
 * Checker for the serial port configuration block: APB read-back, pin
 * drive enables, clock idle level, framed clock and received width.
 * Assumes the register header is on the include path; bound below.
 */
`timescale 1ns/1ns
`include "spi_clock_and_frame_config_regs.vh"
module spi_cfg_checker (
    input wire        pclk,
    input wire        presetn,
    input wire        psel,
    input wire        penable,
    input wire        pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    input wire        pready,
    input wire        serial_clock_pin_out,
    input wire        serial_clock_pin_oe,
    input wire        serial_out_pin_oe,
    input wire        select_pin_oe,
    input wire        tx_busy,
    input wire [15:0] rx_word,
    input wire        rx_valid
);
    // ------------------------------------------------------------
    // Shadow copies of the control registers
    // ------------------------------------------------------------
    reg  [15:0] c1_q;  // Control one as written
    reg  [15:0] c2_q;  // Control two as written
    reg  [1:0]  age_q; // Cycles since last write, saturating
    wire        wr_ok; // Write completes at this edge
    wire        settled; // Outputs had time to follow a write
    assign wr_ok = psel && penable && pready && pwrite;
    assign settled = (age_q == 2'h3);
    // Track writes and how long ago they landed
    always @(posedge pclk or negedge presetn)
        if (!presetn)
        begin
            c1_q  <= 16'h0000;
            c2_q  <= 16'h0000;
            age_q <= 2'h0;
        end
        else if (wr_ok)
        begin
            if (paddr == `CTL_ONE_OFS)
                c1_q <= pwdata[15:0] & `CTL_ONE_MASK;
            if (paddr == `CTL_TWO_OFS)
                c2_q <= pwdata[15:0] & `CTL_TWO_MASK;
            age_q <= 2'h0;
        end
        else if (!settled)
            age_q <= age_q + 2'h1;
    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_read;
        psel && penable && pready && !pwrite;
    endsequence
    sequence s_quiet;
        (!tx_busy)[*3] ##0 settled;
    endsequence
    a_unimpl_zero: assert property (s_read |-> (prdata & {16'hffff,
        (paddr == `CTL_TWO_OFS) ? ~`CTL_TWO_MASK : ~`CTL_ONE_MASK}) == 32'h0000_0000)
        else $error("Unimplemented bits read non-zero");
    a_reg_readback: assert property (s_read ##0 paddr == `CTL_ONE_OFS
        |-> prdata[15:0] == c1_q) else $error("Control one read-back wrong");
    a_clk_drive: assert property (settled |->
        serial_clock_pin_oe == (c1_q[5] && !c1_q[12])) else $error("Clock drive wrong");
    a_sdo_release: assert property (settled && c1_q[11] |-> !serial_out_pin_oe)
        else $error("Data out pin not released");
    a_sync_drive: assert property (settled |->
        select_pin_oe == (c2_q[15] && !c2_q[14])) else $error("Sync pin drive wrong");
    a_clk_idle: assert property (s_quiet ##0 c1_q[5] && !c2_q[15]
        |-> serial_clock_pin_out == c1_q[6]) else $error("Clock idle level wrong");
    a_byte_zero: assert property (rx_valid && !c1_q[10] |->
        rx_word[15:8] == 8'h00) else $error("Byte mode upper half not zero");
    a_framed_clock: assert property (settled && c1_q[5] && !c1_q[12] && c2_q[15]
        |-> ##[1:1000] $changed(serial_clock_pin_out)) else $error("Framed clock stopped");
endmodule // spi_cfg_checker
bind spi_clock_and_frame_config spi_cfg_checker u_spi_cfg_checker (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .serial_clock_pin_out, .serial_clock_pin_oe, .serial_out_pin_oe,
    .select_pin_oe, .tx_busy, .rx_word, .rx_valid);

// *** tb/spi_far_end.sv ***
/*
 * Far-side serial peripheral: returns a word MSB first, collects the
 * device's bits and, when told, makes the link clock for a slave device.
 * Assumes the bench resolves the clock pin and arms it before a word.
 */
`timescale 1ns/1ns
module spi_far_end (
    input  wire        pin_clk,  // Resolved clock pin level
    input  wire        cpol,     // Idle level of the clock
    input  wire        arm,      // Loads word, restarts bit count
    input  wire [15:0] word,     // Word sent to the device
    input  wire        wide,     // 16-bit words when high
    input  wire        drive,    // Rising edge starts own clock
    input  wire        data_in,  // Serial data from the device
    input  wire        late,     // Own data changes on trailing edges
    output reg  [15:0] got,      // Bits taken from the device
    output reg         link_clk, // Own clock, still outside frames
    output wire        data_out  // Serial data to the device
);
    reg [15:0] sh_q;   // Outgoing bits, MSB on the line
    reg        seen_q; // First leading edge passed
    assign data_out = sh_q[15];
    initial link_clk = 1'b0;
    // Load word, byte words sit in the top half
    always @(posedge arm)
    begin
        sh_q = wide ? word : {word[7:0], 8'h00};
        seen_q = 1'b0;
        got = 16'h0000;
        link_clk = cpol;
    end
    // data changes on leading edges after the first, or on
    // trailing edges when late; device bits are taken on the other edge
    always @(pin_clk)
        if (pin_clk !== cpol)
        begin
            if (late)
                got = {got[14:0], data_in};
            else if (seen_q)
                sh_q = {sh_q[14:0], ~sh_q[0]};
            seen_q = 1'b1;
        end
        else if (seen_q)
        begin
            if (late)
                sh_q = {sh_q[14:0], ~sh_q[0]};
            else
                got = {got[14:0], data_in};
        end
    // Own clock, 64 ns period, two edges per bit
    always @(posedge drive)
    begin
        #5;
        repeat (wide ? 32 : 16) #32 link_clk = ~link_clk;
    end
endmodule // spi_far_end

// *** tb/spi_clock_and_frame_config_test.sv ***
/*
 * Bench for the serial port configuration block: register map, slave
 * and master transfers against the far-side model, pin release, sync.
 * Assumes the checker is bound and the header is on the include path.
 */
`timescale 1ns/1ns
module spi_clock_and_frame_config_test;
    reg         pclk, presetn, psel, penable, pwrite, tx_start;
    reg  [11:0] paddr;
    reg  [31:0] pwdata;
    reg  [15:0] tx_word, far_word;
    reg         far_arm, far_drive, far_cpol, far_wide, far_late;
    wire [31:0] prdata;
    wire        pready, pslverr, sck_out, sck_oe, sdo, sdo_oe, sel_out, sel_oe;
    wire        tx_busy, rx_valid, link_clk, far_data, pin_clk;
    wire [15:0] rx_word, far_got;
    integer     n_errors, n_compared, cycles;
    reg  [31:0] rdat;
    reg         rerr;
    // Clock pin level from whoever drives it
    assign pin_clk = sck_oe ? sck_out : link_clk;
    always #4 pclk = ~pclk;
    spi_clock_and_frame_config u_spi_clock_and_frame_config (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .serial_clock_pin_in(pin_clk),
        .serial_clock_pin_out(sck_out), .serial_clock_pin_oe(sck_oe),
        .serial_in_pin(far_data), .serial_out_pin_out(sdo), .serial_out_pin_oe(sdo_oe),
        .select_pin_in(sel_oe ? sel_out : 1'b1), .select_pin_out(sel_out),
        .select_pin_oe(sel_oe), .tx_word(tx_word), .tx_start(tx_start),
        .tx_busy(tx_busy), .rx_word(rx_word), .rx_valid(rx_valid));
    spi_far_end u_spi_far_end (
        .pin_clk(pin_clk), .cpol(far_cpol), .arm(far_arm), .word(far_word),
        .wide(far_wide), .drive(far_drive), .data_in(sdo), .late(far_late),
        .got(far_got), .link_clk(link_clk), .data_out(far_data));
    // ------------------------------------------------------------
    // Bus, compare and closing tasks
    // ------------------------------------------------------------
    task apb(input [11:0] a, input w, input [31:0] d);
    begin
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1)
            @(posedge pclk);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    end
    endtask
    task chk(input [31:0] got, input [31:0] exp);
    begin
        n_compared = n_compared + 1;
        if (got !== exp)
        begin
            n_errors = n_errors + 1;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    end
    endtask
    task rd_chk(input [11:0] a, input [31:0] exp, input err);
    begin
        apb(a, 1'b0, 32'h0000_0000);
        chk(rdat, exp);
        chk({31'h0, rerr}, {31'h0, err});
    end
    endtask
    task load(input [15:0] w, input wide);
    begin
        far_word <= w;
        far_wide <= wide;
        far_arm <= 1'b1;
        @(posedge pclk);
        far_arm <= 1'b0;
    end
    endtask
    // Waits for a received word and compares it
    task rx_chk(input [15:0] exp);
    begin
        @(posedge pclk);
        while (rx_valid !== 1'b1)
            @(posedge pclk);
        chk({16'h0, rx_word}, {16'h0, exp});
    end
    endtask
    task xfer(input [15:0] w, input [15:0] exp);
    begin
        tx_word <= w;
        tx_start <= 1'b1;
        @(posedge pclk);
        tx_start <= 1'b0;
        @(posedge pclk);
        chk({31'h0, tx_busy}, 32'h1);
        rx_chk(exp);
    end
    endtask
    task test_done;
    begin
        if (n_errors == 0 && n_compared > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    end
    endtask
    // Hang guard
    always @(posedge pclk)
    begin
        cycles = cycles + 1;
        if (cycles == 20000)
        begin
            n_errors = n_errors + 1;
            test_done;
        end
    end
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial
    begin
        {pclk, presetn, psel, penable, pwrite, tx_start, far_arm, far_drive, far_late} = 9'h000;
        {far_cpol, far_wide, paddr, pwdata, tx_word, far_word} = 78'h0;
        {n_errors, n_compared, cycles} = 96'h0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd_chk(12'h000, 32'h0000_0000, 1'b0);
        rd_chk(12'h004, 32'h0000_0000, 1'b0);
        rd_chk(12'h008, 32'h0000_0000, 1'b1);
        // Slave byte with far-side clock
        load(16'h003c, 1'b0);
        far_drive <= 1'b1;
        rx_chk(16'h003c);
        far_drive <= 1'b0;
        apb(12'h000, 1'b1, 32'hffff_fe7e);
        rd_chk(12'h000, 32'h0000_1e7e, 1'b0);
        apb(12'h000, 1'b1, 32'h0000_0000);
        apb(12'h004, 1'b1, 32'hffff_fffe);
        rd_chk(12'h004, 32'h0000_e002, 1'b0);
        apb(12'h004, 1'b1, 32'h0000_0000);
        // Master byte then master word with idle-high clock
        apb(12'h000, 1'b1, 32'h0000_0033);
        load(16'h005a, 1'b0);
        xfer(16'h00c3, 16'h005a);
        chk({16'h0, far_got}, 32'h0000_00c3);
        chk({31'h0, sck_oe}, 32'h1);
        far_cpol <= 1'b1;
        apb(12'h000, 1'b1, 32'h0000_0473);
        load(16'hc3a5, 1'b1);
        chk({31'h0, sck_out}, 32'h1);
        xfer(16'h1234, 16'hc3a5);
        chk({16'h0, far_got}, 32'h0000_1234);
        // Sample at end of output time, then output on trailing edges
        apb(12'h000, 1'b1, 32'h0000_0673);
        load(16'h0ff0, 1'b1);
        xfer(16'h00ff, 16'h0ff0);
        chk({16'h0, far_got}, 32'h0000_00ff);
        far_late <= 1'b1;
        apb(12'h000, 1'b1, 32'h0000_0573);
        load(16'h5aa5, 1'b1);
        xfer(16'h8421, 16'h5aa5);
        chk({16'h0, far_got}, 32'h0000_8421);
        far_late <= 1'b0;
        // Clock and data pins handed back
        apb(12'h000, 1'b1, 32'h0000_1833);
        repeat (3) @(posedge pclk);
        chk({30'h0, sck_oe, sdo_oe}, 32'h0);
        // Framed sync pin as output, then as input
        far_cpol <= 1'b0;
        apb(12'h000, 1'b1, 32'h0000_0033);
        apb(12'h004, 1'b1, 32'h0000_8000);
        repeat (3) @(posedge pclk);
        chk({30'h0, sel_oe, sel_out}, 32'h3);
        apb(12'h004, 1'b1, 32'h0000_a000);
        repeat (3) @(posedge pclk);
        chk({30'h0, sel_oe, sel_out}, 32'h2);
        apb(12'h004, 1'b1, 32'h0000_c000);
        repeat (3) @(posedge pclk);
        chk({31'h0, sel_oe}, 32'h0);
        test_done;
    end
endmodule // spi_clock_and_frame_config_test
